// >>> design/mpu_defines.svh
/*
  Address map, field positions and sizes of the protection-unit
  configuration registers (capability, slot selector, bounds, aliases).
  Assumes a 32-bit byte-addressed private register space driven by the core.
*/
// Summary of operation
// [R1] only privileged accesses reach the registers; unprivileged ones raise bus error, no update
// [R2] the core uses only 32-bit word accesses on these registers
// [R3] three limit aliases sit at 0xE000EDA8 plus 8 times (n-1), n is 1 to 3
// [R4] without the main extension the aliases read zero and ignore writes
// [R5] secure code reaches non-secure aliases at 0xE002EDA8 view; others see zero
// [R6] selector, capability and limits are banked per security state; the code keeps one shared capability word for both states
// [R7] alias n acts on region slot[7:2] joined with n; slot stays unchanged
// [R8] limit bits 31:5 hold the upper bound; low five bits fill with 0x1F
// [R9] limit bit 4 reads zero; bits 3:1 are the attribute pointer
// [R10] limit bit 0 enables the region for address checking
// [R11] slot selector at 0xE000ED98 holds bits 7:0; bits 31:8 read zero
// [R12] slot reads zero with no regions; software keeps slot in range
// [R13] slot, bound and attribute pointer hold unknown values after warm reset
// [R14] read-only capability at 0xE000ED90 reports the region count in bits 15:8
// [R15] a region count of zero means no protection unit for that state
// [R16] capability bit 0 reads zero; only unified regions exist
// [R17] non-secure selector and capability views at 0xE002ED98 / 0xE002ED90 for secure only
// [R18] primary limit at 0xE000EDA0 shares the layout, acting on the slot directly
// [R19] lower bound comes from base bits 31:5 with five low zero bits
`ifndef MPU_DEFINES_SVH
`define MPU_DEFINES_SVH
`define PROT_CAP_ADDR 32'hE000ED90
`define SLOT_SEL_ADDR 32'hE000ED98
`define LOWER_PRI_ADDR 32'hE000ED9C
`define UPPER_PRI_ADDR 32'hE000EDA0
`define UPPER_ALIAS_ADDR 32'hE000EDA8
`define ALIAS_LAST_OFS 32'h00000010
`define ALIAS_STEP_LSB 3
`define ALIAS_ALIGN_MASK 32'h00000007
`define SEC_VIEW_HI 16'hE000
`define NS_VIEW_HI 16'hE002
`define REGION_NUM 8
`define REGION_AW 3
`define SLOT_COUNT 8'h08
`define MAIN_EXT 1'b1
`define SLOT_MSB 7
`define SLOT_W 8
`define CNT_LSB 8
`define BOUND_LSB 5
`define BOUND_W 27
`define LOW_FILL 5'h1F
`define LOW_ZERO 5'h00
`define ATTR_LSB 1
`define ATTR_W 3
`define EN_BIT 0
`define BANK_NS 1'b0
`define BANK_S 1'b1
`endif

// >>> design/mpu_pkg.sv
/*
  Types shared by the register block and its region matcher.
  Assumes mpu_defines.svh is on the include path.
*/
`include "mpu_defines.svh"
package mpu_pkg;
  // one access from the core, taken in the cycle req_valid is high
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    logic privileged;
    logic secure;
    logic debugger;
  } reg_req_t;
  // answer, one cycle after the request
  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
    logic bus_error;
  } reg_rsp_t;
  // stored view of one region
  typedef struct packed {
    logic [`BOUND_W-1:0] base;
    logic [4:0] base_attrs;
    logic [`BOUND_W-1:0] limit;
    logic [`ATTR_W-1:0] attr;
    logic en;
  } region_cfg_t;
  typedef region_cfg_t [`REGION_NUM-1:0] region_bank_t;
  // result of an address lookup
  typedef struct packed {
    logic hit;
    logic multi_hit;
    logic [`REGION_AW-1:0] region;
    logic [`ATTR_W-1:0] attr;
  } match_t;
  typedef enum logic [2:0] {K_NONE, K_CAP, K_SLOT, K_LOWER, K_UPPER, K_ALIAS} reg_kind_t;
endpackage : mpu_pkg

// >>> design/region_matcher.sv
/*
  Combinational lookup of one address against all regions of one bank.
  Assumes the caller registers the result; lowest numbered region wins.
*/
`timescale 1ns/1ps
`default_nettype none
module region_matcher
  import mpu_pkg::*;
(
  input wire logic [31:0] check_addr,
  input wire mpu_pkg::region_bank_t bank,
  output mpu_pkg::match_t result
);
  logic [`REGION_NUM-1:0] hit_vec;

  // inclusive bounds: base padded with zeros, limit padded with ones
  genvar g;
  generate
    for (g = 0; g < `REGION_NUM; g++)
    begin : g_cmp
      logic [31:0] lo;
      logic [31:0] hi;
      assign lo = {bank[g].base, `LOW_ZERO}; // see [R19]
      assign hi = {bank[g].limit, `LOW_FILL}; // see [R8]
      assign hit_vec[g] = bank[g].en && (check_addr >= lo) && (check_addr <= hi); // see [R10]
    end
  endgenerate

  // priority pick; an overlap is reported so the caller can fault it
  always_comb
  begin
    result = '0;
    result.multi_hit = (hit_vec & (hit_vec - 1'b1)) != '0;
    for (int i = `REGION_NUM - 1; i >= 0; i--)
    begin
      if (hit_vec[i])
      begin
        result.hit = 1'b1;
        result.region = i[`REGION_AW-1:0];
        result.attr = bank[i].attr;
      end
    end
  end
endmodule : region_matcher
`default_nettype wire

// >>> design/mpu_region_select_limit_regs.sv
/*
  Shared capability, banked slot selector, base, primary limit and limit alias
  registers of the memory protection unit, plus an address check port.
  Assumes the core presents one word access per req_valid pulse and takes
  the answer the following cycle; the core gives its own security state.
*/
`timescale 1ns/1ps
`default_nettype none
module mpu_region_select_limit_regs
  import mpu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire mpu_pkg::reg_req_t req,
  output mpu_pkg::reg_rsp_t rsp,
  input wire logic [31:0] check_addr,
  input wire logic check_secure,
  output mpu_pkg::match_t check_result
);
  import mpu_pkg::*;

  // storage, deliberately without reset: contents are unknown after warm reset
  logic [`SLOT_W-1:0] slot_r [2]; // see [R13]
  region_bank_t bank_r [2]; // see [R6]

  // decoded access
  logic ns_view;
  logic in_space;
  logic view_blocked;
  logic bank_sel;
  logic [31:0] local_addr;
  logic [31:0] alias_ofs;
  logic [1:0] alias_n;
  reg_kind_t kind;
  logic [`SLOT_W-1:0] target_slot;
  logic target_ok;
  logic [`REGION_AW-1:0] target_idx;
  logic [31:0] read_word;
  logic allow_write;
  logic count_zero;
  region_cfg_t cur_cfg;

  // which address view was used; the 0xE002 view is only for secure code
  always_comb
  begin
    ns_view = req.addr[31:16] == `NS_VIEW_HI;
    in_space = ns_view || (req.addr[31:16] == `SEC_VIEW_HI);
    local_addr = {`SEC_VIEW_HI, req.addr[15:0]};
    view_blocked = ns_view && (!req.secure || req.debugger); // see [R5] [R17]
    bank_sel = ns_view ? `BANK_NS : req.secure; // see [R6]
  end

  // alias number from the offset above the first alias
  always_comb
  begin
    alias_ofs = local_addr - `UPPER_ALIAS_ADDR;
    alias_n = alias_ofs[`ALIAS_STEP_LSB+1:`ALIAS_STEP_LSB] + 2'h1; // see [R3]
  end

  // register kind; unlisted offsets decode to nothing and read zero
  always_comb
  begin
    kind = K_NONE;
    if (in_space)
    begin
      if (local_addr == `PROT_CAP_ADDR)
        kind = K_CAP; // see [R14]
      else if (local_addr == `SLOT_SEL_ADDR)
        kind = K_SLOT; // see [R11]
      else if (local_addr == `LOWER_PRI_ADDR)
        kind = K_LOWER;
      else if (local_addr == `UPPER_PRI_ADDR)
        kind = K_UPPER; // see [R18]
      else if ((local_addr >= `UPPER_ALIAS_ADDR)
               && (alias_ofs <= `ALIAS_LAST_OFS)
               && ((alias_ofs & `ALIAS_ALIGN_MASK) == '0)
               && `MAIN_EXT)
        kind = K_ALIAS; // see [R3] [R4]
    end
  end

  // region addressed: slot directly, or slot upper bits with the alias number
  always_comb
  begin
    if (kind == K_ALIAS)
      target_slot = {slot_r[bank_sel][`SLOT_MSB:2], alias_n}; // see [R7]
    else
      target_slot = slot_r[bank_sel]; // see [R18]
    // out-of-range slots are unpredictable; this design reads zero and drops writes
    target_ok = target_slot < `SLOT_COUNT; // see [R12]
    target_idx = target_slot[`REGION_AW-1:0];
    cur_cfg = bank_r[bank_sel][target_idx];
    count_zero = `SLOT_COUNT == '0; // see [R15]
  end

  // read data for the decoded register, reserved bits zero
  always_comb
  begin
    read_word = '0;
    case (kind)
      K_CAP:
      begin
        read_word[`CNT_LSB +: `SLOT_W] = `SLOT_COUNT; // see [R14] [R15]
        read_word[0] = 1'b0; // see [R16]
      end
      K_SLOT:
      begin
        if (!count_zero)
          read_word[`SLOT_W-1:0] = slot_r[bank_sel]; // see [R11] [R12]
      end
      K_LOWER:
      begin
        if (target_ok)
          read_word = {cur_cfg.base, cur_cfg.base_attrs};
      end
      K_UPPER, K_ALIAS:
      begin
        if (target_ok)
        begin
          read_word[31:`BOUND_LSB] = cur_cfg.limit; // see [R8]
          read_word[`ATTR_LSB +: `ATTR_W] = cur_cfg.attr; // see [R9]
          read_word[`EN_BIT] = cur_cfg.en; // see [R10]
        end
      end
      default:
        read_word = '0;
    endcase
    if (view_blocked)
      read_word = '0; // see [R5] [R17]
  end

  // a write lands only for a privileged, unblocked access
  always_comb
  begin
    allow_write = req_valid && req.write && req.privileged && !view_blocked; // see [R1]
  end

  // slot selector, one per bank
  always_ff @(posedge sys_clk)
  begin
    if (allow_write && (kind == K_SLOT) && !count_zero)
      slot_r[bank_sel] <= req.wdata[`SLOT_W-1:0]; // see [R11] [R12]
  end

  // base register of the selected region
  always_ff @(posedge sys_clk)
  begin
    if (allow_write && (kind == K_LOWER) && target_ok)
    begin
      bank_r[bank_sel][target_idx].base <= req.wdata[31:`BOUND_LSB]; // see [R19]
      bank_r[bank_sel][target_idx].base_attrs <= req.wdata[`BOUND_LSB-1:0];
    end
  end

  // primary limit and aliases share one field layout; bit 4 is not stored
  always_ff @(posedge sys_clk)
  begin
    if (allow_write && ((kind == K_UPPER) || (kind == K_ALIAS)) && target_ok)
    begin
      bank_r[bank_sel][target_idx].limit <= req.wdata[31:`BOUND_LSB]; // see [R8]
      bank_r[bank_sel][target_idx].attr <= req.wdata[`ATTR_LSB +: `ATTR_W]; // see [R9]
      bank_r[bank_sel][target_idx].en <= req.wdata[`EN_BIT]; // see [R10]
    end
  end

  // answer one cycle after the request; unprivileged gives bus error and zero data
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rsp <= '0;
    end
    else
    begin
      rsp.valid <= req_valid;
      rsp.bus_error <= req_valid && !req.privileged; // see [R1]
      if (req_valid && !req.write && req.privileged)
        rsp.rdata <= read_word;
      else
        rsp.rdata <= '0;
    end
  end

  // address lookup against the bank of the checking state
  match_t match_nxt;

  region_matcher u_matcher (
    .check_addr(check_addr),
    .bank(bank_r[check_secure]),
    .result(match_nxt)
  );

  // lookup registered so the result is a clean flop output
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      check_result <= '0;
    else
      check_result <= match_nxt; // see [R8] [R10] [R19]
  end
endmodule : mpu_region_select_limit_regs
`default_nettype wire

// >>> dv/mpu_regs_props.sv
/* assertions on the register port only of the protection-unit block;
   bound to its top module, sees only its ports */
`timescale 1ns/1ps
`default_nettype none
module mpu_regs_props
  import mpu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire mpu_pkg::reg_req_t req,
  input wire mpu_pkg::reg_rsp_t rsp,
  input wire logic [31:0] check_addr,
  input wire logic check_secure,
  input wire mpu_pkg::match_t check_result
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // privileged read in the requester's own view
  logic own_rd;
  assign own_rd = req_valid && req.privileged && !req.write && req.addr[31:16] == 16'hE000;
  property p_lat;
    req_valid |=> rsp.valid;
  endproperty
  a_lat: assert property (p_lat)
    else $error("no answer one cycle after request");
  property p_idle;
    !req_valid |=> !rsp.valid && !rsp.bus_error;
  endproperty
  a_idle: assert property (p_idle)
    else $error("answer without request");
  property p_unpriv;
    req_valid && !req.privileged |=> rsp.bus_error && rsp.rdata == 32'h0;
  endproperty
  a_unpriv: assert property (p_unpriv)
    else $error("unprivileged access not refused");
  property p_priv;
    req_valid && req.privileged |=> !rsp.bus_error;
  endproperty
  a_priv: assert property (p_priv)
    else $error("privileged access refused");
  property p_cap;
    own_rd && req.addr[15:0] == 16'hED90 |=> rsp.rdata == 32'h00000800;
  endproperty
  a_cap: assert property (p_cap)
    else $error("capability word wrong");
  property p_slot;
    own_rd && req.addr[15:0] == 16'hED98 |=> rsp.rdata[31:8] == 24'h0;
  endproperty
  a_slot: assert property (p_slot)
    else $error("selector upper bits not zero");
  property p_lim;
    own_rd && req.addr[15:0] inside {16'hEDA0, 16'hEDA8, 16'hEDB0, 16'hEDB8}
      |=> !rsp.rdata[4];
  endproperty
  a_lim: assert property (p_lim)
    else $error("limit bit 4 not zero");
  property p_nsv;
    req_valid && req.addr[31:16] == 16'hE002 && (!req.secure || req.debugger)
      |=> rsp.rdata == 32'h0;
  endproperty
  a_nsv: assert property (p_nsv)
    else $error("foreign view not zero");
endmodule : mpu_regs_props
`default_nettype wire

// >>> dv/core_model.sv
/* core-side model: one word access per request pulse, answer taken
   one cycle later; assumes a free-running sys_clk */
`timescale 1ns/1ps
`default_nettype none
module core_model
  import mpu_pkg::*;
(
  input wire logic sys_clk,
  output logic req_valid,
  output mpu_pkg::reg_req_t req,
  input wire mpu_pkg::reg_rsp_t rsp
);
  // idle until the first access
  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end
  // f is {write, privileged, secure, debugger}; whole words only, no byte lanes
  task automatic acc(input logic [31:0] a, input logic [31:0] d, input logic [3:0] f,
    output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    #1;
    req_valid = 1'b1;
    req = {a, d, f};
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    req = {~a, ~d, 4'h0}; // released: stale values would hide slips
    q = rsp.valid ? rsp.rdata : 32'hDEADBEEF;
    e = rsp.bus_error;
  endtask : acc
endmodule : core_model
`default_nettype wire

// >>> dv/mpu_region_select_limit_regs_tb.sv
/* self-checking bench of the protection-unit registers; the core model
   makes accesses, the bench drives the check port directly */
`timescale 1ns/1ps
`default_nettype none
module mpu_region_select_limit_regs_tb;
  import mpu_pkg::*;
  localparam logic [3:0] WS = 4'hE, WN = 4'hC, RS = 4'h6, RN = 4'h4;
  logic sys_clk, sys_rst, req_valid, check_secure, e;
  logic [31:0] check_addr, q;
  reg_req_t req;
  reg_rsp_t rsp;
  match_t check_result;
  int error_cnt = 0;
  int checks_done = 0;
  mpu_region_select_limit_regs dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req(req), .rsp(rsp), .check_addr(check_addr),
    .check_secure(check_secure), .check_result(check_result));
  core_model core (.sys_clk(sys_clk), .req_valid(req_valid), .req(req), .rsp(rsp));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] f);
    core.acc(a, d, f, q, e);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [3:0] f, input logic [31:0] x);
    core.acc(a, 32'h0, f, q, e);
    chk(q, x);
  endtask : rd
  task automatic t_cap;
    rd(32'hE000ED90, RS, 32'h00000800);
    rd(32'hE000ED90, RN, 32'h00000800);
    core.acc(32'hE000ED90, 32'h0, 4'h2, q, e);
    chk({q[30:0], e}, 32'h1);
  endtask : t_cap
  task automatic t_slot;
    wr(32'hE000ED98, 32'hABCDEF06, WS);
    wr(32'hE000ED98, 32'h2, WN);
    core.acc(32'hE000ED98, 32'h3, 4'hA, q, e);
    chk({31'h0, e}, 32'h1);
    rd(32'hE000ED98, RS, 32'h6);
    rd(32'hE000ED98, RN, 32'h2);
    rd(32'hE002ED98, RS, 32'h2);
    rd(32'hE002ED98, RN, 32'h0);
    rd(32'hE002ED98, 4'h7, 32'h0);
  endtask : t_slot
  task automatic t_alias;
    for (int n = 1; n <= 3; n++)
    begin
      wr(32'hE000ED98, 32'h4, WS);
      wr(32'hE000EDA8 + 8 * (n - 1), 32'h12345611 | (n << 1), WS);
      rd(32'hE000ED98, RS, 32'h4);
      wr(32'hE000ED98, 32'h4 + n, WS);
      rd(32'hE000EDA0, RS, 32'h12345601 | (n << 1));
    end
    rd(32'hE002EDA8, RN, 32'h0);
  endtask : t_alias
  // region 0 spans 0x20000000..0x200000FF with pointer 5, all others off
  task automatic t_check;
    logic [31:0] pa [4] = '{32'h1FFFFFFF, 32'h20000000, 32'h200000FF, 32'h20000100};
    for (int r = 0; r < 8; r++)
    begin
      wr(32'hE000ED98, r, WS);
      wr(32'hE000ED9C, 32'h2000001F, WS);
      wr(32'hE000EDA0, (r == 0) ? 32'h200000EB : 32'h0, WS);
    end
    for (int i = 0; i < 5; i++)
    begin
      if (i == 4)
        wr(32'hE000ED98, 32'h0, WS);
      if (i == 4)
        wr(32'hE000EDA0, 32'h200000EA, WS);
      @(posedge sys_clk);
      #1;
      check_addr = (i == 4) ? 32'h20000000 : pa[i];
      @(posedge sys_clk);
      #1;
      chk(check_result.hit ? 32'(check_result) : 32'h0,
        (i == 1 || i == 2) ? 32'h85 : 32'h0);
    end
  endtask : t_check
  task automatic print_verdict;
    if (error_cnt == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  // 10 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    check_addr = 32'h0;
    check_secure = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    t_cap();
    t_slot();
    t_alias();
    t_check();
    print_verdict();
  end
  // work takes about 115 cycles; roughly seventeen-fold margin (2000 cycles) before giving up
  initial
  begin
    #200000;
    error_cnt++;
    print_verdict();
  end
endmodule : mpu_region_select_limit_regs_tb
bind mpu_region_select_limit_regs mpu_regs_props props (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .rsp(rsp),
  .check_addr(check_addr), .check_secure(check_secure), .check_result(check_result));
`default_nettype wire
